// ==== port_pkg.sv ====
// Constants, register addresses and reset values of the keypad port block
package port_pkg;
  localparam int          NIB_W            = 4;
  localparam int          ADDR_W           = 7;
  // Control register file addresses
  localparam logic [6:0]  ADDR_INT_LEVEL   = 7'h0f;
  localparam logic [6:0]  ADDR_PU_ENABLES  = 7'h17;
  localparam logic [6:0]  ADDR_OD_DIRS     = 7'h26;
  localparam logic [6:0]  ADDR_PP_DIRS     = 7'h27;
  localparam logic [6:0]  ADDR_GROUP_DIRS  = 7'h37;
  localparam logic [6:0]  ADDR_INT_REQ     = 7'h3e;
  // Port data addresses (bank 0 except where noted)
  localparam logic [6:0]  ADDR_PP_DATA     = 7'h6f;
  localparam logic [6:0]  ADDR_KEY_RETURN  = 7'h70;
  localparam logic [6:0]  ADDR_SINGLE_BIT  = 7'h70;  // Bank 1
  localparam logic [6:0]  ADDR_OD_DATA     = 7'h71;
  localparam logic [6:0]  ADDR_GROUP1_DATA = 7'h72;
  localparam logic [6:0]  ADDR_GROUP2_DATA = 7'h73;
  localparam logic        BANK_SINGLE_BIT  = 1'b1;
  // Field positions
  localparam int          INT_BIT          = 0;
  localparam int          GROUP1_DIR_BIT   = 2;
  localparam int          GROUP2_DIR_BIT   = 3;
  // Reset values
  localparam logic [3:0]  NIB_ZERO         = 4'h0;
  localparam logic [3:0]  NIB_ONES         = 4'hf;
  localparam logic [3:0]  GROUP_DIRS_RST   = 4'hc;
  localparam logic [3:0]  OD_DIRS_RST      = 4'h0;
  localparam logic [3:0]  PP_DIRS_RST      = 4'h0;
  localparam logic [3:0]  PU_ENABLES_RST   = 4'h0;
  localparam logic        SINGLE_LATCH_RST = 1'b1;
endpackage : port_pkg

// ==== int_pin_if.sv ====
// Interface between port top and interrupt pin edge detector
`timescale 1ns/1ns
interface int_pin_if;
  logic level;
  logic edge_seen;
  modport detector (output level, output edge_seen);
  modport owner    (input level, input edge_seen);
endinterface : int_pin_if

// ==== int_edge_detect.sv ====
// Synchroniser and both-edge detector for the external interrupt pin
`timescale 1ns/1ns
module int_edge_detect
  import port_pkg::*;
(
  input  wire logic  clock,
  input  wire logic  rst_n,
  input  wire logic  clk_en,
  input  wire logic  int_pin,
  int_pin_if.detector det
);
  logic [2:0] sync_reg;
  logic [2:0] sync_next;

  always_comb begin
    sync_next = sync_reg;
    if (clk_en) begin
      sync_next = {sync_reg[1:0], int_pin};
    end
  end

  // Pin reads low until the chain fills; a pin high out of reset is reported as a rising edge
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sync_reg <= 3'h0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  // Stage 0 is only read by stage 1
  assign det.level     = sync_reg[1];
  assign det.edge_seen = clk_en & (sync_reg[1] ^ sync_reg[2]);
endmodule : int_edge_detect

// ==== keypad_port.sv ====
// Keypad nibble ports, pull-up control and external interrupt flag
`timescale 1ns/1ns
module keypad_port
  import port_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // Register file access (peek/poke and port registers)
  input  wire logic [6:0]  rf_addr,
  input  wire logic        rf_bank,
  input  wire logic        rf_wr,
  input  wire logic [3:0]  rf_wdata,
  output logic      [3:0]  rf_rdata,
  // Pins
  input  wire logic [3:0]  key_return_in,
  input  wire logic [3:0]  od_in,
  output logic      [3:0]  od_out,
  output logic      [3:0]  od_oe,
  output logic      [3:0]  od_pullup,
  input  wire logic [3:0]  group1_in,
  output logic      [3:0]  group1_out,
  output logic      [3:0]  group1_oe,
  output logic      [3:0]  group1_pullup,
  input  wire logic [3:0]  group2_in,
  output logic      [3:0]  group2_out,
  output logic      [3:0]  group2_oe,
  output logic      [3:0]  group2_pullup,
  input  wire logic [3:0]  pp_in,
  output logic      [3:0]  pp_out,
  output logic      [3:0]  pp_oe,
  output logic      [3:0]  pp_pullup,
  input  wire logic        single_in,
  output logic             single_out,
  output logic             single_oe,
  input  wire logic        single_is_output,
  input  wire logic        int_pin,
  output logic             int_request
);
  int_pin_if ipin ();

  int_edge_detect u_int (
    .clock   (clock),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .int_pin (int_pin),
    .det     (ipin.detector)
  );

  // Two-stage synchronisers for every port input
  logic [3:0] kr_s0_reg, kr_s1_reg, od_s0_reg, od_s1_reg;
  logic [3:0] g1_s0_reg, g1_s1_reg, g2_s0_reg, g2_s1_reg;
  logic [3:0] pp_s0_reg, pp_s1_reg;
  logic       sb_s0_reg, sb_s1_reg, mode_s0_reg, mode_s1_reg;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      {kr_s0_reg, kr_s1_reg, od_s0_reg, od_s1_reg} <= {4{NIB_ZERO}};
      {g1_s0_reg, g1_s1_reg, g2_s0_reg, g2_s1_reg} <= {4{NIB_ZERO}};
      {pp_s0_reg, pp_s1_reg}                       <= {2{NIB_ZERO}};
      {sb_s0_reg, sb_s1_reg, mode_s0_reg, mode_s1_reg} <= 4'h0;
    end else if (clk_en) begin
      kr_s0_reg   <= key_return_in;
      kr_s1_reg   <= kr_s0_reg;
      od_s0_reg   <= od_in;
      od_s1_reg   <= od_s0_reg;
      g1_s0_reg   <= group1_in;
      g1_s1_reg   <= g1_s0_reg;
      g2_s0_reg   <= group2_in;
      g2_s1_reg   <= g2_s0_reg;
      pp_s0_reg   <= pp_in;
      pp_s1_reg   <= pp_s0_reg;
      sb_s0_reg   <= single_in;
      sb_s1_reg   <= sb_s0_reg;
      mode_s0_reg <= single_is_output;
      mode_s1_reg <= mode_s0_reg;
    end
  end

  // Control and latch state
  logic [3:0] od_latch_reg, od_latch_next, od_dir_reg, od_dir_next;
  logic [3:0] g1_latch_reg, g1_latch_next, g2_latch_reg, g2_latch_next;
  logic [3:0] group_dir_reg, group_dir_next;
  logic [3:0] pp_latch_reg, pp_latch_next, pp_dir_reg, pp_dir_next;
  logic [3:0] pu_en_reg, pu_en_next;
  logic       sb_latch_reg, sb_latch_next;
  logic       irq_reg, irq_next;

  function automatic logic hit(input logic [6:0] a, input logic b,
                               input logic [6:0] want, input logic want_bank);
    hit = (a == want) && (b == want_bank);
  endfunction : hit

  // Pin value where input, latch where output
  function automatic logic [3:0] port_read(input logic [3:0] dir,
                                           input logic [3:0] latch,
                                           input logic [3:0] pin);
    port_read = (dir & latch) | (~dir & pin);
  endfunction : port_read

  always_comb begin
    od_latch_next  = od_latch_reg;
    od_dir_next    = od_dir_reg;
    g1_latch_next  = g1_latch_reg;
    g2_latch_next  = g2_latch_reg;
    group_dir_next = group_dir_reg;
    pp_latch_next  = pp_latch_reg;
    pp_dir_next    = pp_dir_reg;
    pu_en_next     = pu_en_reg;
    sb_latch_next  = sb_latch_reg;
    irq_next       = irq_reg;
    if (clk_en && rf_wr) begin
      // Latches take writes whatever the direction
      if (hit(rf_addr, rf_bank, ADDR_OD_DATA, 1'b0)) od_latch_next = rf_wdata;
      if (hit(rf_addr, rf_bank, ADDR_GROUP1_DATA, 1'b0)) g1_latch_next = rf_wdata;
      if (hit(rf_addr, rf_bank, ADDR_GROUP2_DATA, 1'b0)) g2_latch_next = rf_wdata;
      if (hit(rf_addr, rf_bank, ADDR_PP_DATA, 1'b0)) pp_latch_next = rf_wdata;
      if (hit(rf_addr, rf_bank, ADDR_SINGLE_BIT, BANK_SINGLE_BIT)) begin
        sb_latch_next = rf_wdata[0];
      end
      if (hit(rf_addr, rf_bank, ADDR_OD_DIRS, 1'b0)) od_dir_next = rf_wdata;
      if (hit(rf_addr, rf_bank, ADDR_PP_DIRS, 1'b0)) pp_dir_next = rf_wdata;
      if (hit(rf_addr, rf_bank, ADDR_GROUP_DIRS, 1'b0)) group_dir_next = rf_wdata;
      if (hit(rf_addr, rf_bank, ADDR_PU_ENABLES, 1'b0)) pu_en_next = rf_wdata;
      if (hit(rf_addr, rf_bank, ADDR_INT_REQ, 1'b0)) irq_next = rf_wdata[INT_BIT];
    end
    // Edge wins over a software clear in the same cycle
    if (ipin.edge_seen) irq_next = 1'b1;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      od_latch_reg  <= NIB_ZERO;
      od_dir_reg    <= OD_DIRS_RST;
      g1_latch_reg  <= NIB_ZERO;
      g2_latch_reg  <= NIB_ZERO;
      group_dir_reg <= GROUP_DIRS_RST;
      pp_latch_reg  <= NIB_ZERO;
      pp_dir_reg    <= PP_DIRS_RST;
      pu_en_reg     <= PU_ENABLES_RST;
      sb_latch_reg  <= SINGLE_LATCH_RST;
      irq_reg       <= 1'b0;
    end else begin
      od_latch_reg  <= od_latch_next;
      od_dir_reg    <= od_dir_next;
      g1_latch_reg  <= g1_latch_next;
      g2_latch_reg  <= g2_latch_next;
      group_dir_reg <= group_dir_next;
      pp_latch_reg  <= pp_latch_next;
      pp_dir_reg    <= pp_dir_next;
      pu_en_reg     <= pu_en_next;
      sb_latch_reg  <= sb_latch_next;
      irq_reg       <= irq_next;
    end
  end

  logic [3:0] g1_dir, g2_dir;
  assign g1_dir = {NIB_W{group_dir_reg[GROUP1_DIR_BIT]}};
  assign g2_dir = {NIB_W{group_dir_reg[GROUP2_DIR_BIT]}};

  // Pin drive straight from latch and direction: no gap on switch-over
  always_comb begin
    od_out        = NIB_ZERO;                       // Open drain only pulls low
    od_oe         = od_dir_reg & ~od_latch_reg;
    od_pullup     = ~od_dir_reg;
    group1_out    = NIB_ZERO;
    group1_oe     = g1_dir & ~g1_latch_reg;
    group1_pullup = ~g1_dir;
    group2_out    = NIB_ZERO;
    group2_oe     = g2_dir & ~g2_latch_reg;
    group2_pullup = ~g2_dir;
    pp_out        = pp_latch_reg;
    pp_oe         = pp_dir_reg;
    pp_pullup     = pu_en_reg;          // Stays on in output too
    single_out    = 1'b0;
    single_oe     = mode_s1_reg & ~sb_latch_reg;
  end

  always_comb begin
    rf_rdata = NIB_ZERO;
    if (hit(rf_addr, rf_bank, ADDR_KEY_RETURN, 1'b0)) rf_rdata = kr_s1_reg;
    if (hit(rf_addr, rf_bank, ADDR_OD_DATA, 1'b0)) begin
      rf_rdata = port_read(od_dir_reg, od_latch_reg, od_s1_reg);
    end
    if (hit(rf_addr, rf_bank, ADDR_GROUP1_DATA, 1'b0)) begin
      rf_rdata = port_read(g1_dir, g1_latch_reg, g1_s1_reg);
    end
    if (hit(rf_addr, rf_bank, ADDR_GROUP2_DATA, 1'b0)) begin
      rf_rdata = port_read(g2_dir, g2_latch_reg, g2_s1_reg);
    end
    if (hit(rf_addr, rf_bank, ADDR_PP_DATA, 1'b0)) begin
      rf_rdata = port_read(pp_dir_reg, pp_latch_reg, pp_s1_reg);
    end
    if (hit(rf_addr, rf_bank, ADDR_SINGLE_BIT, BANK_SINGLE_BIT)) begin
      rf_rdata[0] = mode_s1_reg ? sb_latch_reg : sb_s1_reg;
    end
    if (hit(rf_addr, rf_bank, ADDR_OD_DIRS, 1'b0)) rf_rdata = od_dir_reg;
    if (hit(rf_addr, rf_bank, ADDR_PP_DIRS, 1'b0)) rf_rdata = pp_dir_reg;
    if (hit(rf_addr, rf_bank, ADDR_GROUP_DIRS, 1'b0)) rf_rdata = group_dir_reg;
    if (hit(rf_addr, rf_bank, ADDR_PU_ENABLES, 1'b0)) rf_rdata = pu_en_reg;
    if (hit(rf_addr, rf_bank, ADDR_INT_REQ, 1'b0)) rf_rdata[INT_BIT] = irq_reg;
    if (hit(rf_addr, rf_bank, ADDR_INT_LEVEL, 1'b0)) rf_rdata[INT_BIT] = ipin.level;
  end

  assign int_request = irq_reg;
endmodule : keypad_port

// ==== keypad_port_sva.sv ====
// Assertion checker for the keypad port block
`timescale 1ns/1ns
module keypad_port_sva
  import port_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       clk_en,
  input wire logic [6:0] rf_addr,
  input wire logic       rf_bank,
  input wire logic       rf_wr,
  input wire logic [3:0] rf_wdata,
  input wire logic [3:0] rf_rdata,
  input wire logic [3:0] od_oe,
  input wire logic [3:0] od_pullup,
  input wire logic [3:0] group1_oe,
  input wire logic [3:0] group1_pullup,
  input wire logic [3:0] group2_oe,
  input wire logic [3:0] pp_out,
  input wire logic [3:0] pp_oe,
  input wire logic [3:0] pp_pullup,
  input wire logic       single_oe,
  input wire logic       int_pin,
  input wire logic       int_request
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic wr_ok;
  // Control and port addresses checked here all live in bank 0
  assign wr_ok = rf_wr && clk_en && !rf_bank;
  property p_int_edge; $changed(int_pin) |-> ##[1:5] int_request; endproperty
  a_int_edge: assert property (p_int_edge) else $error("no request after pin edge");
  property p_level;
    $stable(int_pin)[*4] ##0 (rf_addr == ADDR_INT_LEVEL && !rf_bank)
      |-> rf_rdata == {3'h0, int_pin};
  endproperty
  a_level: assert property (p_level) else $error("pin level readback wrong");
  property p_pp_dir;
    wr_ok && rf_addr == ADDR_PP_DIRS |=> pp_oe == $past(rf_wdata) && $stable(pp_out);
  endproperty
  a_pp_dir: assert property (p_pp_dir) else $error("bit direction not applied");
  property p_grp_dir;
    wr_ok && rf_addr == ADDR_GROUP_DIRS
      |=> group1_pullup == {4{~$past(rf_wdata[GROUP1_DIR_BIT])}}
      && ($past(rf_wdata[GROUP2_DIR_BIT]) || group2_oe == 4'h0);
  endproperty
  a_grp_dir: assert property (p_grp_dir) else $error("group direction wrong");
  property p_grp_out;
    wr_ok && rf_addr == ADDR_GROUP1_DATA |=> group1_pullup != 4'h0
      || group1_oe == ~$past(rf_wdata);
  endproperty
  a_grp_out: assert property (p_grp_out) else $error("group latch not driven");
  property p_pu_set; wr_ok && rf_addr == ADDR_PU_ENABLES |=> pp_pullup == $past(rf_wdata);
  endproperty
  a_pu_set: assert property (p_pu_set) else $error("pull-up enables not stored");
  property p_pu_hold; !(wr_ok && rf_addr == ADDR_PU_ENABLES) |=> $stable(pp_pullup);
  endproperty
  a_pu_hold: assert property (p_pu_hold) else $error("pull-up changed unasked");
  property p_rd_latch;
    rf_addr == ADDR_PP_DATA && !rf_bank |-> ((rf_rdata ^ pp_out) & pp_oe) == 4'h0;
  endproperty
  a_rd_latch: assert property (p_rd_latch) else $error("output bit read not latch");
  property p_rst_state;
    $rose(rst_n) |-> group1_oe == 4'hf && group2_oe == 4'hf && od_oe == 4'h0
      && od_pullup == 4'hf && !single_oe && !int_request;
  endproperty
  a_rst_state: assert property (p_rst_state) else $error("reset state wrong");
endmodule : keypad_port_sva
bind keypad_port keypad_port_sva i_sva (.*);

// ==== key_matrix_model.sv ====
// Key matrix model resolving the port lines
`timescale 1ns/1ns
module key_matrix_model (
  input  wire logic [3:0] key_n,
  input  wire logic [3:0] od_oe,
  input  wire logic [3:0] od_pullup,
  input  wire logic [3:0] group1_oe,
  input  wire logic [3:0] group1_pullup,
  input  wire logic [3:0] group2_oe,
  input  wire logic [3:0] group2_pullup,
  input  wire logic [3:0] pp_out,
  input  wire logic [3:0] pp_oe,
  input  wire logic [3:0] pp_pullup,
  output logic      [3:0] od_in,
  output logic      [3:0] group1_in,
  output logic      [3:0] group2_in,
  output logic      [3:0] pp_in
);
  // Pressed key pulls low; an unpulled released line is not a safe 1
  assign od_in     = ~od_oe & key_n & od_pullup;
  assign group1_in = ~group1_oe & key_n & group1_pullup;
  assign group2_in = ~group2_oe & key_n & group2_pullup;
  assign pp_in     = (pp_oe & pp_out) | (~pp_oe & key_n & pp_pullup);
endmodule : key_matrix_model

// ==== keypad_port_tb.sv ====
// Self-checking testbench for the keypad port block
`timescale 1ns/1ns
module keypad_port_tb
  import port_pkg::*;
;
  logic       clock, rst_n, rf_wr, int_pin, single_oe, single_out, int_request;
  logic       rf_bank, single_in, single_is_output;
  logic [6:0] rf_addr;
  logic [3:0] rf_wdata, rf_rdata, key_n, od_in, od_out, od_oe, od_pullup;
  logic [3:0] group1_in, group1_out, group1_oe, group1_pullup;
  logic [3:0] group2_in, group2_out, group2_oe, group2_pullup;
  logic [3:0] pp_in, pp_out, pp_oe, pp_pullup;
  int         mismatches, total_checks;
  keypad_port i_dut (.*, .clk_en(1'b1), .key_return_in(key_n));
  key_matrix_model i_keys (.*);
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [6:0] a, input logic [3:0] d);
    @(posedge clock);
    rf_addr  <= a;
    rf_wdata <= d;
    rf_wr    <= 1'b1;
    @(posedge clock);
    rf_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [3:0] exp);
    @(posedge clock);
    rf_addr <= a;
    #1;
    chk(rf_rdata, exp);
  endtask : rd
  task automatic t_group;
    wr(ADDR_GROUP_DIRS, 4'h0);
    chk(group1_oe | group2_oe, 4'h0);
    wr(ADDR_GROUP1_DATA, 4'ha);
    chk(group1_oe, 4'h0);
    repeat (4) @(posedge clock);
    rd(ADDR_GROUP1_DATA, 4'h5);
    wr(ADDR_GROUP_DIRS, 4'h4);
    chk(group1_oe, 4'h5);
    chk(group2_oe, 4'h0);
    chk(group2_pullup, 4'hf);
    rd(ADDR_GROUP1_DATA, 4'ha);
    wr(ADDR_GROUP1_DATA, 4'h3);
    chk(group1_oe, 4'hc);
    $display("test group done");
  endtask : t_group
  task automatic t_bits;
    wr(ADDR_OD_DATA, 4'h0);
    wr(ADDR_OD_DIRS, 4'h3);
    chk(od_oe, 4'h3);
    chk(od_pullup, 4'hc);
    wr(ADDR_PP_DATA, 4'h9);
    wr(ADDR_PP_DIRS, 4'h6);
    chk(pp_oe, 4'h6);
    chk(pp_out, 4'h9);
    wr(ADDR_PU_ENABLES, 4'h9);
    chk(pp_pullup, 4'h9);
    repeat (4) @(posedge clock);
    rd(ADDR_PP_DATA, 4'h1);
    wr(ADDR_PU_ENABLES, 4'h0);
    chk(pp_pullup, 4'h0);
    $display("test bits done");
  endtask : t_bits
  task automatic t_int;
    @(posedge clock);
    int_pin <= 1'b1;
    @(posedge clock);
    // Clear is taken on the very edge the detected edge sets the flag
    wr(ADDR_INT_REQ, 4'h0);
    chk({3'h0, int_request}, 4'h1);
    repeat (4) @(posedge clock);
    rd(ADDR_INT_LEVEL, 4'h1);
    rd(ADDR_INT_REQ, 4'h1);
    wr(ADDR_INT_REQ, 4'h0);
    chk({3'h0, int_request}, 4'h0);
    @(posedge clock);
    int_pin <= 1'b0;
    repeat (6) @(posedge clock);
    rd(ADDR_INT_LEVEL, 4'h0);
    chk({3'h0, int_request}, 4'h1);
    wr(ADDR_INT_LEVEL, 4'hf);
    rd(ADDR_INT_LEVEL, 4'h0);
    rd(7'h01, 4'h0);
    rd(ADDR_KEY_RETURN, 4'h5);
    $display("test interrupt done");
  endtask : t_int
  task automatic t_single;
    @(posedge clock);
    rf_bank   <= 1'b1;
    single_in <= 1'b0;
    repeat (3) @(posedge clock);
    rd(ADDR_SINGLE_BIT, 4'h0);
    wr(ADDR_SINGLE_BIT, 4'h0);
    chk({3'h0, single_oe}, 4'h0);
    @(posedge clock);
    single_is_output <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    chk({3'h0, single_oe}, 4'h1);
    wr(ADDR_SINGLE_BIT, 4'h1);
    chk({3'h0, single_oe}, 4'h0);
    rd(ADDR_SINGLE_BIT, 4'h1);
    // Bank 1 write to a bank 0 control address must be ignored
    wr(ADDR_PP_DIRS, 4'hf);
    chk(pp_oe, 4'h6);
    @(posedge clock);
    rf_bank <= 1'b0;
    $display("test single done");
  endtask : t_single
  task automatic t_reset;
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    #1;
    chk(group1_oe & group2_oe, 4'hf);
    chk(od_out | group1_out | group2_out, 4'h0);
    chk({3'h0, single_oe}, 4'h0);
    chk({3'h0, single_out}, 4'h0);
    chk(od_oe ^ od_pullup, 4'hf);
    chk({3'h0, int_request}, 4'h0);
    // Mode strap is synchronised; latch reset keeps the pin released
    repeat (3) @(posedge clock);
    #1;
    chk({3'h0, single_oe}, 4'h0);
    $display("test reset done");
  endtask : t_reset
  initial begin
    rst_n            <= 1'b0;
    rf_wr            <= 1'b0;
    rf_addr          <= 7'h00;
    rf_bank          <= 1'b0;
    rf_wdata         <= 4'h0;
    int_pin          <= 1'b0;
    key_n            <= 4'h5;
    single_in        <= 1'b1;
    single_is_output <= 1'b0;
    mismatches       = 0;
    total_checks     = 0;
    t_reset();
    t_group();
    t_bits();
    t_int();
    t_single();
    // Second reset in mid-run, from a state far from reset
    t_reset();
    summarize();
  end
  initial begin
    #20000;
    mismatches++;
    $display("ERROR %0t watchdog expired", $time);
    summarize();
  end
endmodule : keypad_port_tb
